/* acpc_pkg.sv */
// shared constants and carriers of the conversion and power control block
`default_nettype none
package acpc_pkg;

  // result and configuration word sizes
  localparam int RES_W      = 16;
  localparam int CFG_W      = 6;
  localparam int FIFO_DEPTH = 4;

  // configuration word bit positions, first bit shifted in is the msb
  localparam int CFG_SLP_BIT = 0;
  localparam int CFG_UNI_BIT = 1;

  // timing
  localparam int CLK_PERIOD_NS     = 100;
  localparam int CONV_TIME_NS      = 3500;
  localparam int CONV_CYCLES       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_RATE_KSPS  = 200;
  localparam int SAMPLE_PERIOD_CYC = 1000000 / (SAMPLE_RATE_KSPS * CLK_PERIOD_NS);
  localparam int CS_EARLY_LOW_NS   = 100;
  localparam int WAKE_TIME_MS      = 60;
  localparam int CNT_W             = 8;

  // operating modes
  typedef enum logic [3:0] {
    ST_READY = 4'h1,
    ST_CONV  = 4'h2,
    ST_NAP   = 4'h4,
    ST_SLEEP = 4'h8
  } acpc_mode_t;

  // received configuration word
  typedef struct packed {
    logic [3:0] channel;
    logic       unipolar;
    logic       sleep;
  } acpc_cfg_t;

  // power domain enables
  typedef struct packed {
    logic ref_on;
    logic conv_on;
    logic nap;
    logic sleep;
  } acpc_power_t;

endpackage : acpc_pkg
`default_nettype wire

/* acpc_core.sv */
// conversion start, power mode and serial port control with sample buffer
// Contract
// - held high at conversion end: enter nap until the line changes.
// - nap keeps reference and reference buffer on, conversion logic off.
// - line low at conversion end: msb appears on serial output then.
// - line low at conversion end: skip nap, stay fully powered.
// - sleep bit set in received word: power everything down incl. reference.
// - a rising edge of the convert line starts a conversion.
// - rising edges during a running conversion are ignored.
// - serial clock and input ignored during conversion; host keeps lines steady.
// - bipolar results two's complement, unipolar straight binary.
// - conversion timed internally, 200ksps throughput not sustained; 35-cycle conversion plus readout on the synchronised clock exceeds the 50-cycle period.
// - line low after conversion enables shifting result out.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module acpc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // filling side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // draining side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  // pointers wrap freely, so the depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic          full;
    logic          empty;
    logic          ready;
  } acpc_fifo_state_t;

  acpc_fifo_state_t q;
  acpc_fifo_state_t d;
  logic [W-1:0]     mem [DEPTH];
  logic             push;
  logic             pop;

  assign push        = in_valid_i & ~q.full;
  assign pop         = out_ready_i & ~q.empty;
  assign in_ready_o  = q.ready;
  assign out_valid_o = ~q.empty;
  assign out_data_o  = mem[q.rp];

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 1'b1;
      2'b01:   d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    d.full  = (d.cnt == CW'(DEPTH));
    d.empty = (d.cnt == '0);
    d.ready = ~d.full;
    if (rst_i) begin
      d       = '0;
      d.empty = 1'b1;
      d.ready = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
    // storage has no reset; the count alone says what is valid
    if (push) begin
      mem[q.wp] <= in_data_i;
    end
  end
endmodule : acpc_fifo

////////////////////////////////////////////////////////////////////////////////
module acpc_core #(
  parameter int RES_W = acpc_pkg::RES_W,
  parameter int DEPTH = acpc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              SYS_RST_I,
  // serial link pins
  input  wire logic              CONVERT_SELECT_I,
  input  wire logic              SCK_I,
  input  wire logic              SDI_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_O,
  // raw sample codes from the front end
  input  wire logic [RES_W-1:0]  SAMPLE_I,
  input  wire logic              SAMPLE_VALID_I,
  output logic                   SAMPLE_READY_O,
  // status
  output acpc_pkg::acpc_power_t  POWER_O,
  output acpc_pkg::acpc_cfg_t    CONFIG_O,
  output logic                   BUSY_O
);
  import acpc_pkg::*;

  // bit counter reaches the full result length
  localparam int BW = $clog2(RES_W + 1);

  typedef struct packed {
    logic              cs_m;
    logic              cs_s;
    logic              cs_q;
    logic              sck_m;
    logic              sck_s;
    logic              sck_q;
    logic              sdi_m;
    logic              sdi_s;
    acpc_mode_t        mode;
    logic [CNT_W-1:0]  cnt;
    logic [RES_W-1:0]  shift;
    logic [CFG_W-1:0]  cfg_in;
    logic [BW-1:0]     bits;
    acpc_cfg_t         cfg;
    logic              sdo;
    logic              oe;
    acpc_power_t       pwr;
    logic              busy;
  } acpc_core_state_t;

  acpc_core_state_t q;
  acpc_core_state_t d;
  logic [RES_W-1:0] buf_data;
  logic             buf_valid;
  logic             buf_pop;
  logic [RES_W-1:0] code;
  logic             cs_rise;
  logic             cs_fall;
  logic             sck_rise;
  logic             sck_fall;

  //////////////////////////////////////////////////////////////////////////////
  // front end offset-binary code to output coding
  function automatic logic [RES_W-1:0] encode(
    input logic [RES_W-1:0] raw,
    input logic             uni
  );
    encode = uni ? raw : {~raw[RES_W-1], raw[RES_W-2:0]};
  endfunction : encode

  function automatic acpc_power_t power_of(input acpc_mode_t m);
    acpc_power_t p;
    p = '0;
    case (m)
      ST_NAP: begin
        p.ref_on = 1'b1;
        p.nap    = 1'b1;
      end
      ST_SLEEP: begin
        p.sleep = 1'b1;
      end
      default: begin
        p.ref_on  = 1'b1;
        p.conv_on = 1'b1;
      end
    endcase
    power_of = p;
  endfunction : power_of

  //////////////////////////////////////////////////////////////////////////////
  // samples wait here until a conversion ends; drained one per conversion
  acpc_fifo #(
    .W     (RES_W),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .in_data_i   (SAMPLE_I),
    .in_valid_i  (SAMPLE_VALID_I),
    .in_ready_o  (SAMPLE_READY_O),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin edges, taken only from the second and third stages
  assign cs_rise  = q.cs_s & ~q.cs_q;
  assign cs_fall  = ~q.cs_s & q.cs_q;
  assign sck_rise = q.sck_s & ~q.sck_q;
  assign sck_fall = ~q.sck_s & q.sck_q;

  //////////////////////////////////////////////////////////////////////////////
  // mode sequencing, serial port and power domains
  always_comb begin
    d       = q;
    buf_pop = 1'b0;
    code    = encode(buf_valid ? buf_data : '0, q.cfg.unipolar);
    // two-stage synchronisers
    d.cs_m  = CONVERT_SELECT_I;
    d.cs_s  = q.cs_m;
    d.cs_q  = q.cs_s;
    d.sck_m = SCK_I;
    d.sck_s = q.sck_m;
    d.sck_q = q.sck_s;
    d.sdi_m = SDI_I;
    d.sdi_s = q.sdi_m;
    d.oe    = ~q.cs_s;
    case (q.mode)
      ST_CONV: begin
        // serial pins and new edges ignored here
        d.oe = 1'b0;
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == CNT_W'(CONV_CYCLES - 1)) begin
          buf_pop = buf_valid;
          d.shift = code;
          d.sdo   = code[RES_W-1];
          d.bits  = '0;
          d.cnt   = '0;
          if (q.cs_s) begin
            d.mode = ST_NAP;
          end else begin
            // line already low: port opens with the msb at once
            d.mode = ST_READY;
            d.oe   = 1'b1;
          end
        end
      end
      ST_NAP: begin
        if (!q.cs_s) begin
          d.mode = ST_READY;
        end
      end
      default: begin
        if (cs_rise) begin
          // a short frame keeps the previous configuration
          if (q.bits >= BW'(CFG_W)) begin
            d.cfg = q.cfg_in;
          end
          // a word with the sleep bit set skips the conversion
          if (d.cfg.sleep) begin
            d.mode = ST_SLEEP;
          end else begin
            d.mode = ST_CONV;
            d.cnt  = '0;
          end
          d.oe = 1'b0;
        end else if (!q.cs_s) begin
          if (cs_fall) begin
            d.bits = '0;
            d.sdo  = q.shift[RES_W-1];
          end else if (sck_rise) begin
            if (q.bits < BW'(CFG_W)) begin
              d.cfg_in = {q.cfg_in[CFG_W-2:0], q.sdi_s};
            end
            if (q.bits < BW'(RES_W)) begin
              d.bits = q.bits + 1'b1;
            end
          end else if (sck_fall) begin
            // next bit follows the fall, so it is settled at the rise
            d.shift = {q.shift[RES_W-2:0], 1'b0};
            d.sdo   = q.shift[RES_W-2];
          end
        end
      end
    endcase
    d.pwr  = power_of(d.mode);
    d.busy = (d.mode == ST_CONV);
    if (SYS_RST_I) begin
      // synchronisers clear too: a line high at release starts a conversion
      d      = '0;
      d.mode = ST_READY;
      d.pwr  = power_of(ST_READY);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK_I) begin
    q <= d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign SDO_O    = q.sdo;
  assign SDO_OE_O = q.oe;
  assign POWER_O  = q.pwr;
  assign CONFIG_O = q.cfg;
  assign BUSY_O   = q.busy;
endmodule : acpc_core
`default_nettype wire

/* acpc_core_checker.sv */
// port assertions of the conversion and power control block
`timescale 1ns/1ps
`default_nettype none
module acpc_core_checker (
  // clock and reset
  input wire logic                  CLK_I,
  input wire logic                  SYS_RST_I,
  // watched pins
  input wire logic                  CONVERT_SELECT_I,
  input wire logic                  SDO_OE_O,
  input wire logic                  BUSY_O,
  input wire acpc_pkg::acpc_power_t POWER_O,
  input wire acpc_pkg::acpc_cfg_t   CONFIG_O
);
  import acpc_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_busy_len: assert property (
    $rose(BUSY_O) |-> ##34 BUSY_O ##1 !BUSY_O) else $error("conversion length wrong");
  chk_start_cause: assert property (
    $rose(BUSY_O) |-> $past(CONVERT_SELECT_I, 2) || $past(CONVERT_SELECT_I, 3)
      || $past(CONVERT_SELECT_I, 4)) else $error("conversion without start edge");
  chk_nap_entry: assert property (
    CONVERT_SELECT_I [*4] ##0 $fell(BUSY_O) |-> POWER_O == 4'hA) else $error("no nap");
  chk_nap_hold: assert property (
    CONVERT_SELECT_I [*4] ##0 POWER_O.nap |=> POWER_O.nap) else $error("nap left early");
  chk_nap_power: assert property (
    POWER_O.nap |-> POWER_O.ref_on && !POWER_O.conv_on) else $error("nap power wrong");
  chk_low_end: assert property (
    !CONVERT_SELECT_I [*4] ##0 $fell(BUSY_O) |-> SDO_OE_O && POWER_O == 4'hC)
    else $error("low end wrong");
  chk_quiet_conv: assert property (
    BUSY_O && $past(BUSY_O) |-> !SDO_OE_O && $stable(CONFIG_O)) else $error("port active");
  chk_sleep_power: assert property (
    CONFIG_O.sleep |-> POWER_O == 4'h1 && !BUSY_O) else $error("sleep power wrong");
  cover property (POWER_O.nap);
  cover property (POWER_O.sleep);
  cover property ($fell(BUSY_O) && SDO_OE_O);
endmodule : acpc_core_checker
////////////////////////////////////////
bind acpc_core acpc_core_checker u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CONVERT_SELECT_I(CONVERT_SELECT_I),
  .SDO_OE_O(SDO_OE_O), .BUSY_O(BUSY_O), .POWER_O(POWER_O), .CONFIG_O(CONFIG_O));
`default_nettype wire

/* acpc_host_model.sv */
// serial master model of the host side
`timescale 1ns/1ps
`default_nettype none
module acpc_host_model #(
  parameter int WAKE_NS = 60000000
) (
  // bench clock
  input  wire logic clk_i,
  // serial link
  output logic      cs_o,
  output logic      sck_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    cs_o = 1'b0;
    sck_o = 1'b0;
    sdi_o = 1'b1;
  end
  task automatic start(input logic hold);
    @(negedge clk_i) cs_o = 1'b1;
    if (!hold) @(negedge clk_i) cs_o = 1'b0;
  endtask : start
  // clock idles low; result read late in the high half
  task automatic frame(input logic [5:0] cfg, output logic [15:0] res);
    @(negedge clk_i) cs_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = (i >= 10) ? cfg[i-10] : 1'b0;
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      res[i] = sdo_i;
      sck_o = 1'b0;
    end
    sdi_o = ~sdi_o;
  endtask : frame
  task automatic wake();
    #(WAKE_NS);
  endtask : wake
endmodule : acpc_host_model
`default_nettype wire

/* acpc_core_tb.sv */
// self-checking bench of the conversion and power control block
`timescale 1ns/1ps
`default_nettype none
module acpc_core_tb;
  import acpc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sv = 1'b0;
  logic [15:0] sd = 16'h0000;
  logic        cs, sck, sdi, sdo, oe, sr, busy;
  logic        sdo_line;
  logic [15:0] res;
  acpc_power_t pwr;
  acpc_cfg_t   cfg;
  int          err_count = 0;
  int          check_count = 0;
  logic [15:0] w [5] = '{16'h1234, 16'h8001, 16'hFFFF, 16'h0F0F, 16'h5555};
  always #50 clk = ~clk;
  // a released data line shows the inverse of its last bit
  assign sdo_line = oe ? sdo : ~sdo;
  acpc_host_model #(.WAKE_NS(6000)) host (
    .clk_i(clk), .cs_o(cs), .sck_o(sck), .sdi_o(sdi), .sdo_i(sdo_line));
  acpc_core dut (
    .CLK_I(clk), .SYS_RST_I(rst), .CONVERT_SELECT_I(cs), .SCK_I(sck), .SDI_I(sdi),
    .SDO_O(sdo), .SDO_OE_O(oe), .SAMPLE_I(sd), .SAMPLE_VALID_I(sv),
    .SAMPLE_READY_O(sr), .POWER_O(pwr), .CONFIG_O(cfg), .BUSY_O(busy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t ns: %s got %h", $time, what, got);
    end
  endtask : chk
  // optional second edge lands mid conversion
  task automatic conv(input logic hold, input logic again);
    host.start(hold);
    repeat (6) @(negedge clk);
    chk(16'(busy), 16'h0001, "busy");
    if (again) host.start(1'b0);
    repeat (35) @(negedge clk);
    chk(16'(busy), 16'h0000, "done");
  endtask : conv
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // five words offered, the fifth refused by the full buffer
  task automatic test_fill();
    sv = 1'b1;
    for (int i = 0; i < 5; i++) begin
      sd = w[i];
      @(negedge clk);
    end
    sv = 1'b0;
    chk(16'(sr), 16'h0000, "full");
    $display("test fill done");
  endtask : test_fill
  task automatic test_nap();
    conv(1'b1, 1'b0);
    chk(16'(pwr), 16'h000A, "nap");
    repeat (20) @(negedge clk);
    chk(16'(pwr), 16'h000A, "nap hold");
    host.frame(6'h0E, res);
    chk(res, 16'h9234, "bipolar");
    chk(16'(pwr), 16'h000C, "nap exit");
    $display("test nap done");
  endtask : test_nap
  task automatic test_pulse();
    conv(1'b0, 1'b1);
    chk(16'({oe, sdo, pwr, cfg}), {4'h0, 2'b11, 4'hC, 6'h0E}, "low end");
    host.frame(6'h01, res);
    chk(res, 16'h8001, "unipolar");
    $display("test pulse done");
  endtask : test_pulse
  task automatic test_sleep();
    host.start(1'b1);
    repeat (45) @(negedge clk);
    chk(16'({busy, pwr, cfg}), {5'h00, 1'b0, 4'h1, 6'h01}, "sleep");
    host.frame(6'h00, res);
    host.wake();
    conv(1'b1, 1'b0);
    host.frame(6'h00, res);
    chk(res, 16'h7FFF, "wake");
    $display("test sleep done");
  endtask : test_sleep
  // mid-run reset clears the port and flushes the buffer
  task automatic test_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({sdo, oe, busy, sr, pwr, cfg}), {2'b00, 4'b0001, 4'hC, 6'h00}, "reset");
    rst = 1'b0;
    repeat (2) @(negedge clk);
    conv(1'b0, 1'b0);
    chk(16'({oe, sdo}), 16'h0003, "flushed msb");
    host.frame(6'h00, res);
    chk(res, 16'h8000, "flushed");
    $display("test reset done");
  endtask : test_reset
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    test_fill();
    test_nap();
    test_pulse();
    test_sleep();
    test_reset();
    final_report();
  end
  // limit about ten times the expected run
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule : acpc_core_tb
`default_nettype wire
